//--- ltg_pkg.sv
/*
 * ltg_pkg: shared constants for the list driven trigger generator.
 * assumes: one bus clock of 125 MHz, register port with byte-wide index addresses.
 */
package ltg_pkg;

   // ==========================================================================
   // register port geometry
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;

   // ==========================================================================
   // register offsets
   localparam logic [7:0] OFS_CONTROL      = 8'h00;
   localparam logic [7:0] OFS_STATUS       = 8'h01;
   localparam logic [7:0] OFS_COUNT        = 8'h02;
   localparam logic [7:0] OFS_BASE_POINTER = 8'h03;
   localparam logic [7:0] OFS_LIST_ZERO    = 8'h04;
   localparam logic [7:0] OFS_LIST_ONE     = 8'h05;
   localparam logic [7:0] OFS_DEBUG        = 8'h06;

   // ==========================================================================
   // control register fields
   localparam int unsigned CTL_ENABLE_BIT  = 0;
   localparam int unsigned CTL_LOAD_OK_BIT = 1;
   localparam int unsigned CTL_LIST_BIT    = 2;

   // status register fields
   localparam int unsigned STS_DONE_BIT    = 0;
   localparam int unsigned STS_OVERRUN_BIT = 1;

   // debug register fields
   localparam int unsigned DBG_FORCE_TRIG_BIT   = 0;
   localparam int unsigned DBG_FORCE_RELOAD_BIT = 2;
   localparam int unsigned DBG_TRIG_PIN_BIT     = 4;
   localparam int unsigned DBG_RELOAD_PIN_BIT   = 6;
   localparam logic [7:0]  DBG_STORED_MASK      = 8'h50;

   // ==========================================================================
   // widths, reset values and counts
   localparam int unsigned PTR_W      = 24;
   localparam int unsigned IDX_W      = 8;
   localparam int unsigned VAL_W      = 16;
   localparam int unsigned NUM_W      = 5;
   localparam logic [23:0] PTR_RESET  = 24'h000000;
   localparam logic [7:0]  IDX_RESET  = 8'h00;
   localparam logic [7:0]  LIST_ZERO_OFFSET = 8'h00;
   localparam logic [7:0]  DBG_RESET  = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] END_OF_LIST_MARKER = 16'h0000;
   localparam logic [4:0]  LAST_TRIGGER_NUM = 5'h1F;
   localparam logic [7:0]  ENTRY_BYTES = 8'h02;

   // ==========================================================================
   // generator sequence, gray coded along idle-fetch-wait-done
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_WAIT  = 2'b11,
      ST_DONE  = 2'b10
   } ltg_state_t;

endpackage

//--- ltg_list_fetch.sv
/*
 * ltg_list_fetch: one-word read engine toward the system memory read port.
 * assumes: memory holds a level request until a one-cycle acknowledge with data;
 * dropping the request abandons the read.
 */
`timescale 1ns/100ps
`default_nettype none

module ltg_list_fetch (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // control from the generator
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic [23:0] base,
   input  wire logic [7:0]  offset,
   // memory read port
   output logic             mem_req,
   output logic [23:0]      mem_addr,
   input  wire logic        mem_ack,
   input  wire logic [15:0] mem_data,
   // result toward the generator
   output logic             word_valid,
   output logic [15:0]      word
);

   // ==========================================================================
   // address inside the window
   logic [23:0] window_addr;

   assign window_addr = base + {16'h0000, offset};

   // ==========================================================================
   // request and result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req    <= 1'b0;
         mem_addr   <= ltg_pkg::PTR_RESET;
         word_valid <= 1'b0;
         word       <= ltg_pkg::COUNT_RESET;
      end else begin
         word_valid <= 1'b0;
         if (abort) begin
            mem_req <= 1'b0;
         end else if (start) begin
            mem_req  <= 1'b1;
            mem_addr <= window_addr;
         end else if (mem_req && mem_ack) begin
            mem_req    <= 1'b0;
            word_valid <= 1'b1;
            word       <= mem_data;
         end
      end
   end

endmodule

`default_nettype wire

//--- ltg_trigger_gen.sv
/*
 * ltg_trigger_gen: list driven trigger generator with one generator.
 * assumes: reload input, mode inputs and memory port run on MCLK; pins are
 * driven from flip-flops with their own output enables.
 */
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - time base count reads back only, and stops once the list is finished
// - each reload clears and restarts the count and fetches the first entry
// - 24-bit base pointer; writes ignored while the generator is enabled
// - list zero offset always reads zero, list zero starts at base
// - list one offset gives its start, writable only while disabled
// - debug register reads always, takes writes only in special mode
// - debug bit 6 enables the reload indication pin output
// - debug bit 4 enables the trigger indication pin output
// - debug bit 2 written one while enabled forces a reload, reads zero
// - forced reload sets no overrun flag, pulses reload output one cycle
// - debug bit 0 written one while enabled forces one trigger, reads zero
// - forced reload and trigger are blocked in stop or freeze mode
// - disabled generator makes no triggers and issues no memory reads
// - triggering follows the reload, which also signals a new control cycle
// - a match of count and current value emits a trigger
// - after each trigger the next value is fetched, at most 32 per cycle
// - end marker or 32 triggers sets done and idles until reload
// - short lists raise done only after the marker fetch completes
// - reads stay inside the 256-byte window above the base pointer
// - load-ok at reload swaps lists and clears load-ok, then loads first value
// - each entry is a 16-bit delay counted in bus cycles from reload
module ltg_trigger_gen (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RESET_N,
   // register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   // device mode
   input  wire logic        SPECIAL_MODE,
   input  wire logic        STOP_MODE,
   input  wire logic        FREEZE_MODE,
   // reload from the controlled module
   input  wire logic        RELOAD_IN,
   input  wire logic        RELOAD_ASYNC,
   // system memory read port
   output logic             MEM_RD_REQ,
   output logic [23:0]      MEM_RD_ADDR,
   input  wire logic        MEM_RD_ACK,
   input  wire logic [15:0] MEM_RD_DATA,
   // toward the controlled module and error logic
   output logic             TRIGGER,
   output logic             RELOAD_OUT,
   output logic             GENERATOR_ENABLE,
   output logic             GENERATOR_DONE_FLAG,
   output logic             LIST_LOAD_OK,
   // indication pins
   output logic             RELOAD_INDICATION_PIN,
   output logic             RELOAD_PIN_OUTPUT_ENABLE,
   output logic             TRIGGER_INDICATION_PIN,
   output logic             TRIGGER_PIN_OUTPUT_ENABLE
);

   // ==========================================================================
   // functions
   function automatic logic [7:0] entry_offset(input logic [7:0] list_idx,
                                               input logic [4:0] entry);
      logic [7:0] step;
      step = {3'b000, entry} * ltg_pkg::ENTRY_BYTES;
      entry_offset = list_idx + step;
   endfunction

   function automatic logic is_write(input logic wr, input logic [7:0] addr,
                                     input logic [7:0] ofs);
      is_write = wr && (addr == ofs);
   endfunction

   // ==========================================================================
   // state
   ltg_pkg::ltg_state_t state;
   ltg_pkg::ltg_state_t next_state;
   logic        generator_enable;
   logic        list_load_ok;
   logic        active_list_select;
   logic        generator_done_flag;
   logic        reload_overrun_flag;
   logic [23:0] list_base_pointer;
   logic [7:0]  list_one_offset;
   logic [7:0]  debug_control;
   logic [15:0] time_base_count;
   logic [15:0] trigger_value;
   logic [4:0]  trigger_num;
   logic        trigger_pulse;
   logic        reload_pulse;

   // ==========================================================================
   // register decode
   logic wr_control;
   logic wr_status;
   logic wr_pointer;
   logic wr_list_one;
   logic wr_debug;

   assign wr_control  = is_write(REG_WR, REG_ADDR, ltg_pkg::OFS_CONTROL);
   assign wr_status   = is_write(REG_WR, REG_ADDR, ltg_pkg::OFS_STATUS);
   assign wr_pointer  = is_write(REG_WR, REG_ADDR, ltg_pkg::OFS_BASE_POINTER) && !generator_enable;
   assign wr_list_one = is_write(REG_WR, REG_ADDR, ltg_pkg::OFS_LIST_ONE) && !generator_enable;
   assign wr_debug    = is_write(REG_WR, REG_ADDR, ltg_pkg::OFS_DEBUG) && SPECIAL_MODE;

   // ==========================================================================
   // debug forcing
   logic force_allowed;
   logic force_reload;
   logic force_trigger;

   assign force_allowed = generator_enable && !STOP_MODE && !FREEZE_MODE;
   assign force_reload  = wr_debug && REG_WDATA[ltg_pkg::DBG_FORCE_RELOAD_BIT] && force_allowed;
   assign force_trigger = wr_debug && REG_WDATA[ltg_pkg::DBG_FORCE_TRIG_BIT] && force_allowed;

   // ==========================================================================
   // reload and list selection
   logic reload_event;
   logic swap_list;
   logic next_list;
   logic set_overrun;
   logic set_load_ok;
   logic [7:0] active_offset;

   assign reload_event = generator_enable && (RELOAD_IN || force_reload);
   assign swap_list    = reload_event && list_load_ok;
   assign next_list    = swap_list ? !active_list_select : active_list_select;
   assign set_overrun  = reload_event && !list_load_ok && !force_reload && !RELOAD_ASYNC;
   assign set_load_ok  = wr_control && REG_WDATA[ltg_pkg::CTL_LOAD_OK_BIT];
   assign active_offset = next_list ? list_one_offset : ltg_pkg::LIST_ZERO_OFFSET;

   // ==========================================================================
   // list fetch
   logic       fetch_start;
   logic       fetch_abort;
   logic [4:0] fetch_entry;
   logic [7:0] fetch_offset;
   logic       word_valid;
   logic [15:0] word;
   logic       is_marker;
   logic       count_match;
   logic       last_trigger;

   assign fetch_abort  = !generator_enable || reload_event;
   assign count_match  = (state == ltg_pkg::ST_WAIT) && (time_base_count == trigger_value);
   assign last_trigger = (trigger_num == ltg_pkg::LAST_TRIGGER_NUM);
   assign fetch_start  = (reload_event || (count_match && !last_trigger)) && generator_enable;
   assign fetch_entry  = reload_event ? 5'h00 : trigger_num + 5'h01;
   assign fetch_offset = entry_offset(active_offset, fetch_entry);
   assign is_marker    = (word == ltg_pkg::END_OF_LIST_MARKER);

   ltg_list_fetch u_fetch (
      .clk        (MCLK),
      .rst_n      (RESET_N),
      .start      (fetch_start),
      .abort      (fetch_abort && !fetch_start),
      .base       (list_base_pointer),
      .offset     (fetch_offset),
      .mem_req    (MEM_RD_REQ),
      .mem_addr   (MEM_RD_ADDR),
      .mem_ack    (MEM_RD_ACK),
      .mem_data   (MEM_RD_DATA),
      .word_valid (word_valid),
      .word       (word)
   );

   // ==========================================================================
   // generator sequence
   always_comb begin
      next_state = state;
      case (state)
         ltg_pkg::ST_IDLE: begin
            if (reload_event) begin
               next_state = ltg_pkg::ST_FETCH;
            end
         end
         ltg_pkg::ST_FETCH: begin
            if (word_valid) begin
               next_state = is_marker ? ltg_pkg::ST_DONE : ltg_pkg::ST_WAIT;
            end
         end
         ltg_pkg::ST_WAIT: begin
            if (count_match) begin
               next_state = last_trigger ? ltg_pkg::ST_DONE : ltg_pkg::ST_FETCH;
            end
         end
         ltg_pkg::ST_DONE: begin
            next_state = ltg_pkg::ST_DONE;
         end
         default: begin
            next_state = ltg_pkg::ST_IDLE;
         end
      endcase
      if (reload_event) begin
         next_state = ltg_pkg::ST_FETCH;
      end
      if (!generator_enable) begin
         next_state = ltg_pkg::ST_IDLE;
      end
   end

   logic set_done;

   assign set_done = ((state == ltg_pkg::ST_FETCH) && word_valid && is_marker && !reload_event)
                  || (count_match && last_trigger && !reload_event);

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= ltg_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================================
   // time base counter and trigger bookkeeping
   logic counting;

   assign counting = (state == ltg_pkg::ST_FETCH) || (state == ltg_pkg::ST_WAIT);

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         time_base_count <= ltg_pkg::COUNT_RESET;
      end else if (reload_event) begin
         time_base_count <= ltg_pkg::COUNT_RESET;
      end else if (counting) begin
         time_base_count <= time_base_count + 16'h0001;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         trigger_value <= ltg_pkg::COUNT_RESET;
         trigger_num   <= 5'h00;
      end else if (reload_event) begin
         trigger_num   <= 5'h00;
      end else begin
         if ((state == ltg_pkg::ST_FETCH) && word_valid) begin
            trigger_value <= word;
         end
         if (count_match) begin
            trigger_num <= trigger_num + 5'h01;
         end
      end
   end

   // ==========================================================================
   // trigger and reload pulses
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         trigger_pulse <= 1'b0;
         reload_pulse  <= 1'b0;
      end else begin
         trigger_pulse <= (count_match && !reload_event) || force_trigger;
         reload_pulse  <= reload_event;
      end
   end

   // ==========================================================================
   // control and status registers
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         generator_enable    <= 1'b0;
         list_load_ok        <= 1'b0;
         active_list_select  <= 1'b0;
         generator_done_flag <= 1'b0;
         reload_overrun_flag <= 1'b0;
      end else begin
         if (wr_control) begin
            generator_enable <= REG_WDATA[ltg_pkg::CTL_ENABLE_BIT];
         end
         // reload clears load-ok, software set wins
         list_load_ok <= set_load_ok || (list_load_ok && !reload_event);
         if (wr_control && !generator_enable) begin
            active_list_select <= REG_WDATA[ltg_pkg::CTL_LIST_BIT];
         end else begin
            active_list_select <= next_list;
         end
         generator_done_flag <= set_done
            || (generator_done_flag && !(wr_status && REG_WDATA[ltg_pkg::STS_DONE_BIT]));
         reload_overrun_flag <= set_overrun
            || (reload_overrun_flag && !(wr_status && REG_WDATA[ltg_pkg::STS_OVERRUN_BIT]));
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         list_base_pointer <= ltg_pkg::PTR_RESET;
         list_one_offset   <= ltg_pkg::IDX_RESET;
         debug_control     <= ltg_pkg::DBG_RESET;
      end else begin
         if (wr_pointer) begin
            list_base_pointer <= REG_WDATA[23:0];
         end
         if (wr_list_one) begin
            list_one_offset <= REG_WDATA[7:0];
         end
         if (wr_debug) begin
            debug_control <= REG_WDATA[7:0] & ltg_pkg::DBG_STORED_MASK;
         end
      end
   end

   // ==========================================================================
   // read path
   logic [31:0] read_mux;

   always_comb begin
      read_mux = 32'h00000000;
      case (REG_ADDR)
         ltg_pkg::OFS_CONTROL: begin
            read_mux[ltg_pkg::CTL_ENABLE_BIT]  = generator_enable;
            read_mux[ltg_pkg::CTL_LOAD_OK_BIT] = list_load_ok;
            read_mux[ltg_pkg::CTL_LIST_BIT]    = active_list_select;
         end
         ltg_pkg::OFS_STATUS: begin
            read_mux[ltg_pkg::STS_DONE_BIT]    = generator_done_flag;
            read_mux[ltg_pkg::STS_OVERRUN_BIT] = reload_overrun_flag;
         end
         ltg_pkg::OFS_COUNT:        read_mux[15:0] = time_base_count;
         ltg_pkg::OFS_BASE_POINTER: read_mux[23:0] = list_base_pointer;
         ltg_pkg::OFS_LIST_ZERO:    read_mux[7:0]  = ltg_pkg::LIST_ZERO_OFFSET;
         ltg_pkg::OFS_LIST_ONE:     read_mux[7:0]  = list_one_offset;
         ltg_pkg::OFS_DEBUG:        read_mux[7:0]  = debug_control;
         default:                   read_mux       = 32'h00000000;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= 32'h00000000;
      end else begin
         REG_RDATA <= REG_RD ? read_mux : 32'h00000000;
      end
   end

   // ==========================================================================
   // outputs
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TRIGGER                   <= 1'b0;
         RELOAD_OUT                <= 1'b0;
         GENERATOR_ENABLE          <= 1'b0;
         GENERATOR_DONE_FLAG       <= 1'b0;
         LIST_LOAD_OK              <= 1'b0;
         RELOAD_INDICATION_PIN     <= 1'b0;
         RELOAD_PIN_OUTPUT_ENABLE  <= 1'b0;
         TRIGGER_INDICATION_PIN    <= 1'b0;
         TRIGGER_PIN_OUTPUT_ENABLE <= 1'b0;
      end else begin
         TRIGGER                   <= trigger_pulse;
         RELOAD_OUT                <= reload_pulse;
         GENERATOR_ENABLE          <= generator_enable;
         GENERATOR_DONE_FLAG       <= generator_done_flag;
         LIST_LOAD_OK              <= list_load_ok;
         RELOAD_INDICATION_PIN     <= reload_pulse;
         TRIGGER_INDICATION_PIN    <= trigger_pulse;
         RELOAD_PIN_OUTPUT_ENABLE  <= debug_control[ltg_pkg::DBG_RELOAD_PIN_BIT];
         TRIGGER_PIN_OUTPUT_ENABLE <= debug_control[ltg_pkg::DBG_TRIG_PIN_BIT];
      end
   end

endmodule

`default_nettype wire

//--- ltg_mem_model.sv
/*
 * ltg_mem_model: list memory behind the generator's read port.
 * assumes: request held as a level until one ack cycle; dly sets the wait.
 */
`timescale 1ns/100ps
`default_nettype none

module ltg_mem_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // read port
   input  wire logic        req,
   input  wire logic [23:0] addr,
   output logic             ack,
   output logic [15:0]      data,
   // answer wait in cycles
   input  wire logic [1:0]  dly
);
   logic [15:0] mem [0:127];
   logic [15:0] q;
   logic [1:0]  cnt;

   // ==========
   // answer; outside ack the data lines show the inverse
   assign data = ack ? q : ~q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         cnt <= 2'h0;
         q <= 16'h0000;
      end else begin
         ack <= 1'b0;
         if (!req || ack) begin
            cnt <= 2'h0;
         end else if (cnt == dly) begin
            ack <= 1'b1;
            q <= mem[addr[7:1]];
         end else begin
            cnt <= cnt + 2'h1;
         end
      end
   end
endmodule

`default_nettype wire

//--- ltg_assertions.sv
/*
 * ltg_checker: port-level properties of the trigger generator.
 * assumes: bound to ltg_trigger_gen, one clock MCLK.
 */
`timescale 1ns/100ps
`default_nettype none

module ltg_checker (
   // watched ports
   input wire logic        MCLK,
   input wire logic        RESET_N,
   input wire logic [7:0]  REG_ADDR,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        SPECIAL_MODE,
   input wire logic        MEM_RD_REQ,
   input wire logic        TRIGGER,
   input wire logic        RELOAD_OUT,
   input wire logic        GENERATOR_ENABLE,
   input wire logic        RELOAD_PIN_OUTPUT_ENABLE,
   input wire logic        TRIGGER_PIN_OUTPUT_ENABLE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   // ==========
   // assertions
   a_trig_one_cycle: assert property (TRIGGER |=> !TRIGGER)
      else $error("trigger pulse too long");
   a_reload_one_cycle: assert property (RELOAD_OUT |=> !RELOAD_OUT)
      else $error("reload pulse too long");
   a_idle_no_read: assert property (!GENERATOR_ENABLE [*3] |-> !MEM_RD_REQ)
      else $error("read while disabled");
   a_idle_no_trig: assert property (!GENERATOR_ENABLE [*4] |-> !TRIGGER)
      else $error("trigger while disabled");
   a_dbg_strobe_zero: assert property ($past(REG_RD) && $past(REG_ADDR) == ltg_pkg::OFS_DEBUG
      |-> (REG_RDATA & 32'h00000005) == 32'h00000000) else $error("debug strobe bit read one");
   a_list_zero_ro: assert property ($past(REG_RD) && $past(REG_ADDR) == ltg_pkg::OFS_LIST_ZERO
      |-> REG_RDATA == 32'h00000000) else $error("list zero offset not zero");
   a_rpin_en_hold: assert property (!(REG_WR && REG_ADDR == ltg_pkg::OFS_DEBUG && SPECIAL_MODE) [*3]
      |-> $stable(RELOAD_PIN_OUTPUT_ENABLE)) else $error("reload pin enable moved");
   a_tpin_en_hold: assert property (!(REG_WR && REG_ADDR == ltg_pkg::OFS_DEBUG && SPECIAL_MODE) [*3]
      |-> $stable(TRIGGER_PIN_OUTPUT_ENABLE)) else $error("trigger pin enable moved");
endmodule

bind ltg_trigger_gen ltg_checker u_chk (.MCLK(MCLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SPECIAL_MODE(SPECIAL_MODE), .MEM_RD_REQ(MEM_RD_REQ),
   .TRIGGER(TRIGGER), .RELOAD_OUT(RELOAD_OUT), .GENERATOR_ENABLE(GENERATOR_ENABLE),
   .RELOAD_PIN_OUTPUT_ENABLE(RELOAD_PIN_OUTPUT_ENABLE), .TRIGGER_PIN_OUTPUT_ENABLE(TRIGGER_PIN_OUTPUT_ENABLE));

`default_nettype wire

//--- testbench.sv
/*
 * testbench: random and corner runs of the trigger generator.
 * assumes: ltg_mem_model serves list reads; the bench plays software.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // ==========
   // signals
   logic        MCLK, RESET_N, REG_WR, REG_RD, SPECIAL_MODE, STOP_MODE, FREEZE_MODE, RELOAD_IN, RELOAD_ASYNC;
   logic        MEM_RD_REQ, MEM_RD_ACK, TRIGGER, RELOAD_OUT, GENERATOR_ENABLE, GENERATOR_DONE_FLAG, LIST_LOAD_OK;
   logic        RELOAD_INDICATION_PIN, RELOAD_PIN_OUTPUT_ENABLE, TRIGGER_INDICATION_PIN, TRIGGER_PIN_OUTPUT_ENABLE;
   logic [7:0]  REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA;
   logic [23:0] MEM_RD_ADDR, ptr;
   logic [15:0] MEM_RD_DATA;
   logic [1:0]  dly;
   logic        dn;
   int          errors, n_compared, cyc, n_rl, n0, v, r;
   int          t_trg [$];
   logic [23:0] a_req [$];

   ltg_trigger_gen DUT (.MCLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .SPECIAL_MODE,
      .STOP_MODE, .FREEZE_MODE, .RELOAD_IN, .RELOAD_ASYNC, .MEM_RD_REQ, .MEM_RD_ADDR, .MEM_RD_ACK, .MEM_RD_DATA,
      .TRIGGER, .RELOAD_OUT, .GENERATOR_ENABLE, .GENERATOR_DONE_FLAG, .LIST_LOAD_OK, .RELOAD_INDICATION_PIN,
      .RELOAD_PIN_OUTPUT_ENABLE, .TRIGGER_INDICATION_PIN, .TRIGGER_PIN_OUTPUT_ENABLE);
   ltg_mem_model MEM (.clk(MCLK), .rst_n(RESET_N), .req(MEM_RD_REQ), .addr(MEM_RD_ADDR), .ack(MEM_RD_ACK),
      .data(MEM_RD_DATA), .dly(dly));

   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   // ==========
   // monitor
   always @(negedge MCLK) begin
      cyc = cyc + 1;
      if ({TRIGGER, TRIGGER_INDICATION_PIN} === 2'b11) begin
         t_trg.push_back(cyc);
         dn = GENERATOR_DONE_FLAG;
      end
      if ({RELOAD_OUT, RELOAD_INDICATION_PIN} === 2'b11) n_rl = n_rl + 1;
      if (MEM_RD_REQ === 1'b1 && MEM_RD_ACK === 1'b1) a_req.push_back(MEM_RD_ADDR);
   end
   // ==========
   // tasks
   task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
      @(posedge MCLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
      @(posedge MCLK);
      {REG_RD, REG_ADDR} <= {1'b1, a};
      @(posedge MCLK);
      REG_RD <= 1'b0;
      @(negedge MCLK);
      check(REG_RDATA, e, m);
   endtask
   task automatic pulse;
      @(posedge MCLK);
      RELOAD_IN <= 1'b1;
      @(posedge MCLK);
      RELOAD_IN <= 1'b0;
   endtask
   task automatic run(input int n, input logic [7:0] o);
      int k;
      dly <= 2'($urandom);
      wr(8'h01, 32'h3);
      t_trg.delete();
      a_req.delete();
      r = n_rl;
      pulse();
      for (k = 0; k < 3000 && GENERATOR_DONE_FLAG !== 1'b1; k++) @(posedge MCLK);
      rc(8'h02, 32'(k - 2), "count halted");
      repeat (6) @(posedge MCLK);
      check(32'(n_rl - r), 32'h1, "reload out");
      check(32'(t_trg.size()), 32'(n), "trigger count");
      check(32'(a_req.size()), 32'(n < 32 ? n + 1 : 32), "fetch count");
      for (k = 0; k < a_req.size(); k++) check(32'(a_req[k]), 32'({ptr[23:8], o + 8'(2 * k)}), "addr");
      for (k = 1; k < t_trg.size(); k++)
         check(32'(t_trg[k] - t_trg[0]), 32'(MEM.mem[o / 2 + k] - MEM.mem[o / 2]), "spacing");
      if (n < 32) check(32'(dn), 32'h0, "done early");
      rc(8'h01, 32'(o ? 1 : 3), "done flag");
   endtask
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #(8 * 40000);
      errors++;
      wrap_up();
   end
   // ==========
   // main sequence
   initial begin
      {REG_WR, REG_RD, SPECIAL_MODE, STOP_MODE, FREEZE_MODE, RELOAD_IN, RELOAD_ASYNC, RESET_N} = 8'h00;
      {REG_ADDR, REG_WDATA, dly, errors, n_compared, cyc, n_rl} = '0;
      void'($urandom(32'hA63B));
      repeat (3) @(posedge MCLK);
      RESET_N <= 1'b1;
      for (int a = 2; a < 8; a++) rc(a == 7 ? 8'h3F : 8'(a), 32'h0, "reset value");
      ptr = {16'($urandom), 8'h00};
      n0 = 1 + $urandom % 5;
      v = 0;
      for (int i = 0; i < 40; i++) begin
         v = v + 20 + $urandom % 40;
         if (i < 8) MEM.mem[i] = i < n0 ? 16'(v) : 16'h0000;
         MEM.mem[32 + i] = 16'(10 + 12 * i);
      end
      wr(8'h03, 32'(ptr));
      wr(8'h05, 32'h40);
      wr(8'h02, 32'hFFFF);
      rc(8'h03, 32'(ptr), "pointer");
      rc(8'h05, 32'h40, "list one");
      rc(8'h02, 32'h0, "count read only");
      wr(8'h06, 32'h50);
      rc(8'h06, 32'h0, "debug locked");
      SPECIAL_MODE <= 1'b1;
      wr(8'h06, 32'h55);
      rc(8'h06, 32'h50, "debug stored");
      check(32'({RELOAD_PIN_OUTPUT_ENABLE, TRIGGER_PIN_OUTPUT_ENABLE}), 32'h3, "pin enables");
      check(32'(t_trg.size() + n_rl), 32'h0, "forced while off");
      wr(8'h06, 32'h10);
      wr(8'h00, 32'h1);
      check(32'({RELOAD_PIN_OUTPUT_ENABLE, TRIGGER_PIN_OUTPUT_ENABLE}), 32'h1, "pin enables");
      $display("registers done");
      wr(8'h03, 32'h0);
      wr(8'h05, 32'h0);
      rc(8'h03, 32'(ptr), "pointer locked");
      rc(8'h05, 32'h40, "list one locked");
      run(n0, 8'h00);
      repeat (2) wr(8'h00, 32'h3);
      check(32'(LIST_LOAD_OK), 32'h1, "load ok set");
      run(32, 8'h40);
      rc(8'h00, 32'h5, "list swapped");
      $display("lists done");
      for (int m = 2; m >= 0; m--) begin
         {STOP_MODE, FREEZE_MODE} <= {m == 1, m == 2};
         t_trg.delete();
         r = n_rl;
         wr(8'h06, 32'h55);
         repeat (4) @(posedge MCLK);
         check(32'(t_trg.size() + n_rl - r), 32'(m == 0 ? 2 : 0), "forced ops");
      end
      repeat (600) @(posedge MCLK);
      rc(8'h01, 32'h1, "no overrun");
      wr(8'h00, 32'h0);
      a_req.delete();
      r = n_rl;
      pulse();
      repeat (30) @(posedge MCLK);
      check(32'(a_req.size() + n_rl - r), 32'h0, "disabled");
      $display("forced and disabled done");
      wrap_up();
   end
endmodule

`default_nettype wire
